// ==== spims_pkg.sv ====
package spims_pkg;

  // APB address width and register word indices
  localparam int         ADDR_W   = 12;
  localparam logic [9:0] IDX_CTRL = 10'h02c;
  localparam logic [9:0] IDX_STAT = 10'h02d;
  localparam logic [9:0] IDX_DATA = 10'h02e;
  localparam logic [9:0] IDX_PINS = 10'h02f;

  // Control register fields
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_EN     = 6;
  localparam int CTRL_LSB    = 5;
  localparam int CTRL_MASTER_SELECT   = 4;
  localparam int CTRL_CLOCK_POLARITY   = 3;
  localparam int CTRL_CLOCK_PHASE   = 2;
  localparam int CTRL_RATE_H = 1;
  localparam int CTRL_RATE_L = 0;

  // Status register fields
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_DBL  = 0;

  // Pin control register fields
  localparam int PINS_MOSI_DIR = 0;
  localparam int PINS_MISO_DIR = 1;
  localparam int PINS_SCK_DIR  = 2;
  localparam int PINS_SS_DIR   = 3;
  localparam int PINS_SS_LEVEL = 4;
  localparam int PINS_GIE      = 5;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic       DBL_RST  = 1'h0;
  localparam logic [5:0] PINS_RST = 6'h00;

  // Edge count of one byte: 16 edges, last index
  localparam logic [3:0] LAST_EDGE = 4'hf;

  // SCK divisors by {double, rate_hi, rate_lo}
  localparam int DIV_0 = 4;
  localparam int DIV_1 = 16;
  localparam int DIV_2 = 64;
  localparam int DIV_3 = 128;
  localparam int DIV_4 = 2;
  localparam int DIV_5 = 8;
  localparam int DIV_6 = 32;
  localparam int DIV_7 = 64;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } spims_xfer_e;

  // Pins as seen from outside, already resolved
  typedef struct packed {
    logic sck_i;
    logic mosi_i;
    logic miso_i;
    logic ss_i;
  } spims_pin_in_s;

  // Pin drive values and enables
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_o;
    logic ss_oe;
  } spims_pin_out_s;

  // Half SCK period minus one, in pclk cycles
  function automatic logic [6:0] spims_half(input logic [2:0] code);
    logic [6:0] h;
    h = 7'(DIV_0 / 2 - 1);
    unique case (code)
      3'h0: h = 7'(DIV_0 / 2 - 1);
      3'h1: h = 7'(DIV_1 / 2 - 1);
      3'h2: h = 7'(DIV_2 / 2 - 1);
      3'h3: h = 7'(DIV_3 / 2 - 1);
      3'h4: h = 7'(DIV_4 / 2 - 1);
      3'h5: h = 7'(DIV_5 / 2 - 1);
      3'h6: h = 7'(DIV_6 / 2 - 1);
      3'h7: h = 7'(DIV_7 / 2 - 1);
    endcase
    return h;
  endfunction

endpackage

// ==== spims_top.sv ====
`timescale 1ns/10ps
module spims_top (
  input  wire logic                        pclk,    // System clock
  input  wire logic                        presetn, // Async reset, low
  input  wire logic                        psel,    // APB select
  input  wire logic                        penable, // APB access phase
  input  wire logic                        pwrite,  // APB write
  input  wire logic [spims_pkg::ADDR_W-1:0] paddr,  // APB byte address
  input  wire logic [31:0]                 pwdata,  // APB write data
  output logic      [31:0]                 prdata,  // APB read data
  output logic                             pready,  // APB ready
  output logic                             pslverr, // APB error
  input  wire logic                        irq_ack, // Vector taken
  input  wire spims_pkg::spims_pin_in_s    pin_in,  // Pin levels
  output spims_pkg::spims_pin_out_s        pin_out, // Pin drives
  output logic                             irq      // Interrupt
);
  import spims_pkg::*;

  // Whole state of the port in one record
  typedef struct packed {
    logic [7:0]     ctrl;    // Control register
    logic           dbl;     // Double speed bit
    logic           done;    // Transfer done flag
    logic           write_collision_flag;    // Write collision flag
    logic           armed;   // Status read saw a flag
    logic [5:0]     pins;    // Pin control register
    spims_xfer_e    st;      // Master transfer state
    logic [3:0]     edges;   // SCK edges in this byte
    logic [6:0]     div;     // Half period counter
    logic           sck;     // Master SCK level
    logic           ser;     // Serial out bit
    logic [7:0]     shreg;   // Shift register
    logic [7:0]     txbyte;  // Copy for slave restart
    logic [7:0]     rxbuf;   // Receive buffer
    logic [2:0]     sck_sy;  // SCK sync and edge tap
    logic [1:0]     ss_sy;   // Select sync
    logic [1:0]     mosi_sy; // MOSI sync
    logic [1:0]     miso_sy; // MISO sync
    logic [31:0]    prdata;  // Read data
    logic           pready;  // Ready
    logic           pslverr; // Error
    logic           irq;     // Interrupt
    spims_pin_out_s po;      // Pin drives
  } spims_state_s;

  spims_state_s r;      // Registered state
  spims_state_s n;      // Next state

  // Decoded views of the current state
  logic       en;       // Port enabled
  logic       master_select;     // Master role
  logic       clock_polarity;     // Idle level
  logic       clock_phase;     // Phase
  logic       lsb;      // LSB first
  logic       ss_low;   // Synchronised select low
  logic       slv_act;  // Selected slave
  logic       busy;     // Byte in flight
  logic       fault;    // Mode fault
  logic       edge_ev;  // One SCK edge now
  logic       sample;   // Capture edge
  logic       setup;    // Launch edge
  logic       fin;      // Last edge of byte
  logic       in_bit;   // Bit being captured
  logic       out_bit;  // Bit to launch
  logic [7:0] shifted;  // Shift register after capture

  // APB decode
  logic       acc;      // Access phase, not yet ready
  logic       done_acc; // Access completes this edge
  logic       hit_ctrl; // Control selected
  logic       hit_stat; // Status selected
  logic       hit_data; // Data selected
  logic       hit_pins; // Pin control selected
  logic       hit_any;  // Mapped address
  logic       wr_data;  // Data write completes
  logic       rd_stat;  // Status read completes
  logic       acc_data; // Any data access completes

  // Next-state logic for the whole port
  always_comb begin
    n = r;

    en   = r.ctrl[CTRL_EN];
    master_select = r.ctrl[CTRL_MASTER_SELECT];
    clock_polarity = r.ctrl[CTRL_CLOCK_POLARITY];
    clock_phase = r.ctrl[CTRL_CLOCK_PHASE];
    lsb  = r.ctrl[CTRL_LSB];

    // Bit order picks the end of the register
    out_bit = lsb ? r.shreg[0] : r.shreg[7];

    // Only the second sync stage is looked at
    ss_low  = ~r.ss_sy[1];
    slv_act = en & ~master_select & ss_low;

    // APB address decode on word index
    hit_ctrl = (paddr[ADDR_W-1:2] == IDX_CTRL);
    hit_stat = (paddr[ADDR_W-1:2] == IDX_STAT);
    hit_data = (paddr[ADDR_W-1:2] == IDX_DATA);
    hit_pins = (paddr[ADDR_W-1:2] == IDX_PINS);
    hit_any  = hit_ctrl | hit_stat | hit_data | hit_pins;
    acc      = psel & penable & ~r.pready;
    done_acc = psel & penable & r.pready;
    wr_data  = done_acc & pwrite & hit_data;
    rd_stat  = done_acc & ~pwrite & hit_stat;
    acc_data = done_acc & hit_data;

    // In flight: master shifting, or slave mid-byte
    busy = (r.st == ST_SHIFT) | (slv_act & (r.edges != 4'h0));

    // Another master pulls our select input low
    fault = en & master_select & ~r.pins[PINS_SS_DIR] & ss_low;

    // Edge source depends on role
    if (master_select) begin
      edge_ev = (r.st == ST_SHIFT) & (r.div == 7'h00);
      in_bit  = r.miso_sy[1];
    end else begin
      // Slave edges from sync taps, needs slow SCK
      edge_ev = slv_act & (r.sck_sy[1] != r.sck_sy[2]);
      in_bit  = r.mosi_sy[1];
    end

    // Even edges lead, odd trail; phase picks capture
    sample = edge_ev & (r.edges[0] == clock_phase);
    setup  = edge_ev & (r.edges[0] != clock_phase);
    fin    = edge_ev & (r.edges == LAST_EDGE);

    shifted = lsb ? {in_bit, r.shreg[7:1]}
                  : {r.shreg[6:0], in_bit};

    // Two-stage synchronisers for every input pin
    n.sck_sy  = {r.sck_sy[1:0], pin_in.sck_i};
    n.ss_sy   = {r.ss_sy[0], pin_in.ss_i};
    n.mosi_sy = {r.mosi_sy[0], pin_in.mosi_i};
    n.miso_sy = {r.miso_sy[0], pin_in.miso_i};

    // Master bit clock: toggle every half period
    if (r.st == ST_SHIFT) begin
      if (r.div == 7'h00) begin
        n.div = spims_half({r.dbl, r.ctrl[CTRL_RATE_H:CTRL_RATE_L]});
        n.sck = ~r.sck;
      end else begin
        n.div = r.div - 7'h01;
      end
    end else begin
      // Idle level follows polarity
      n.sck = clock_polarity;
    end

    // Edge bookkeeping, launch and capture apart
    if (edge_ev) begin
      n.edges = r.edges + 4'h1;
    end
    if (sample) begin
      n.shreg = shifted;
    end
    if (setup) begin
      n.ser = out_bit;
    end
    // Phase zero: first bit stands before first edge
    if (!clock_phase && r.edges == 4'h0 && !edge_ev) begin
      n.ser = out_bit;
    end

    // End of byte: buffer it, raise flag
    if (fin) begin
      n.rxbuf  = n.shreg;
      n.txbyte = n.shreg;
      n.st     = ST_IDLE;
      n.edges  = 4'h0;
    end

    // Deselected slave drops partial byte
    if (!master_select && !slv_act) begin
      n.edges = 4'h0;
      n.shreg = r.txbyte;
    end

    // Port disabled: no serial activity at all
    if (!en) begin
      n.st    = ST_IDLE;
      n.edges = 4'h0;
    end

    // Register writes take effect at the ready edge
    if (done_acc && pwrite) begin
      if (hit_ctrl) begin
        // Role from the master select bit
        n.ctrl = pwdata[7:0];
      end
      if (hit_stat) begin
        n.dbl = pwdata[STAT_DBL];
      end
      if (hit_pins) begin
        n.pins = pwdata[5:0];
      end
    end

    // Data write: load, or flag collision
    if (wr_data) begin
      if (!busy) begin
        n.shreg  = pwdata[7:0];
        n.txbyte = pwdata[7:0];
        // First bit out now; divide by two leaves no idle cycle
        n.ser    = lsb ? pwdata[0] : pwdata[7];
        if (en && master_select) begin
          // Start the bit clock for eight bits
          n.st    = ST_SHIFT;
          n.edges = 4'h0;
          n.div   = spims_half({r.dbl,
                                r.ctrl[CTRL_RATE_H:CTRL_RATE_L]});
          n.sck   = clock_polarity;
        end
      end
    end

    // Mode fault drops to slave; only software restores
    if (fault) begin
      n.ctrl[CTRL_MASTER_SELECT] = 1'b0;
      n.st              = ST_IDLE;
      n.edges           = 4'h0;
    end

    // Status read showing a flag arms the clear
    if (rd_stat) begin
      n.armed = r.prdata[STAT_DONE] | r.prdata[STAT_WRITE_COLLISION_FLAG];
    end
    if (acc_data && r.armed) begin
      n.done  = 1'b0;
      n.write_collision_flag  = 1'b0;
      n.armed = 1'b0;
    end
    // Vector taken clears the done flag
    if (irq_ack) begin
      n.done = 1'b0;
    end
    // Sets come last so they win over a clear
    if (fin || fault) begin
      n.done = 1'b1;
    end
    if (wr_data && busy) begin
      n.write_collision_flag = 1'b1;
    end

    // APB answer: one wait cycle, then ready
    n.pready  = acc;
    n.pslverr = acc & ~hit_any;
    n.prdata  = 32'h0000_0000;
    if (acc && !pwrite) begin
      unique case (1'b1)
        hit_ctrl: n.prdata[7:0] = r.ctrl;
        // Reserved bits five to one stay zero
        hit_stat: n.prdata[7:0] = {r.done, r.write_collision_flag, 5'h00, r.dbl};
        hit_data: n.prdata[7:0] = r.rxbuf;
        hit_pins: n.prdata[5:0] = r.pins;
        default:  n.prdata      = 32'h0000_0000;
      endcase
    end

    // Interrupt needs flag, enable and global enable
    n.irq = r.done & r.ctrl[CTRL_IRQ_EN] & r.pins[PINS_GIE];

    // Master SCK and MOSI as user directs; slave SCK and MOSI inputs
    n.po.sck_o   = n.sck;
    n.po.sck_oe  = en & master_select & r.pins[PINS_SCK_DIR];
    n.po.mosi_o  = n.ser;
    n.po.mosi_oe = en & master_select & r.pins[PINS_MOSI_DIR];
    n.po.miso_o  = n.ser;
    // Selected slave drives MISO only when user says
    n.po.miso_oe = slv_act & r.pins[PINS_MISO_DIR];
    // Select as plain output when off or master, input when enabled slave
    n.po.ss_o    = r.pins[PINS_SS_LEVEL];
    n.po.ss_oe   = r.pins[PINS_SS_DIR] & (~en | master_select);
  end

  // State register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.ctrl    <= CTRL_RST;
      r.dbl     <= DBL_RST;
      r.pins    <= PINS_RST;
      r.st      <= ST_IDLE;
      r.sck_sy  <= 3'h0;
      r.ss_sy   <= 2'h3;
      r.shreg   <= 8'h00;
      r.txbyte  <= 8'h00;
    end else begin
      r <= n;
    end
  end

  // Every output straight from the state register
  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign pin_out = r.po;
  assign irq     = r.irq;

endmodule // spims_top

// ==== spims_chk.sv ====
`timescale 1ns/10ps
module spims_chk (
  input wire logic                         pclk,    // Clock
  input wire logic                         presetn, // Reset
  input wire logic                         psel,    // Select
  input wire logic                         penable, // Access
  input wire logic                         pwrite,  // Write
  input wire logic [spims_pkg::ADDR_W-1:0] paddr,   // Address
  input wire logic [31:0]                  pwdata,  // Write data
  input wire logic [31:0]                  prdata,  // Read data
  input wire logic                         pready,  // Ready
  input wire spims_pkg::spims_pin_in_s     pin_in,  // Pins in
  input wire spims_pkg::spims_pin_out_s    pin_out  // Pins out
);
  import spims_pkg::*;
  localparam int DV [8] = '{4, 16, 64, 128, 2, 8, 32, 64}; // Divisors
  logic [7:0] c_reg;    // Control copy
  logic [5:0] p_reg;    // Pin control copy
  logic       d_reg;    // Double speed copy
  logic       busy_reg; // Master byte running
  logic       sck_reg;  // Last sck
  logic [6:0] gap_reg;  // Cycles since sck moved
  logic [3:0] n_reg;    // Sck edges so far
  logic       wr;       // Write taken
  logic       mv;       // Sck moved
  logic [9:0] ix;       // Word index
  assign ix = paddr[11:2];
  assign wr = psel & penable & pready & pwrite;
  assign mv = pin_out.sck_o != sck_reg;
  // Copies follow APB writes; busy spans sixteen sck edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_reg <= 8'h00;
      p_reg <= 6'h00;
      d_reg <= 1'b0;
      busy_reg <= 1'b0;
      sck_reg <= 1'b0;
      gap_reg <= 7'h00;
      n_reg <= 4'h0;
    end else begin
      sck_reg <= pin_out.sck_o;
      gap_reg <= mv ? 7'h00 : gap_reg + 7'h01;
      if (wr && ix == IDX_CTRL) c_reg <= pwdata[7:0];
      if (wr && ix == IDX_PINS) p_reg <= pwdata[5:0];
      if (wr && ix == IDX_STAT) d_reg <= pwdata[0];
      if (busy_reg && mv) begin
        n_reg <= n_reg + 4'h1;
        if (n_reg == 4'hf) busy_reg <= 1'b0;
      end
      // Mode fault not mirrored: bench rewrites control after one
      if (wr && ix == IDX_DATA && c_reg[6] && c_reg[4] && !busy_reg) begin
        busy_reg <= 1'b1;
        gap_reg <= 7'h00;
        n_reg <= 4'h0;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rsvd;
    pready && !pwrite && ix == IDX_STAT |-> prdata[5:1] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  property p_rate;
    busy_reg && mv && n_reg != 4'h0 |->
      gap_reg == 7'(DV[{d_reg, c_reg[1:0]}] / 2 - 1);
  endproperty
  a_rate: assert property (p_rate) else $error("sck rate");
  property p_start;
    busy_reg |-> gap_reg < 7'd66;
  endproperty
  a_start: assert property (p_start) else $error("sck stalled");
  property p_idle;
    !busy_reg && pin_out.sck_oe && c_reg[6] && c_reg[4] &&
      $past(c_reg, 2) == c_reg |-> pin_out.sck_o == c_reg[3];
  endproperty
  a_idle: assert property (p_idle) else $error("sck idle");
  property p_gpio;
    c_reg[6] && c_reg[4] && p_reg[3] && $past(p_reg) == p_reg &&
      $past(c_reg) == c_reg |-> pin_out.ss_oe && pin_out.ss_o == p_reg[4];
  endproperty
  a_gpio: assert property (p_gpio) else $error("ss output");
  property p_miso;
    !p_reg[1] && !$past(p_reg[1]) |-> !pin_out.miso_oe;
  endproperty
  a_miso: assert property (p_miso) else $error("miso driven");
  property p_off;
    !c_reg[6] && $past(c_reg, 2) == c_reg |->
      !pin_out.miso_oe && $stable(pin_out.sck_o);
  endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_fault;
    (c_reg[6] && c_reg[4] && !p_reg[3] && !pin_in.ss_i) [*4] |->
      ##[0:8] !pin_out.sck_oe && !pin_out.mosi_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");
endmodule // spims_chk

bind spims_top spims_chk chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pin_in, .pin_out);

// ==== spims_slv_model.sv ====
`timescale 1ns/10ps
// Far-side peripheral, MSB first, any of the four modes
module spims_slv_model (
  input  wire logic       sck,  // Serial clock
  input  wire logic       ss_n, // Select
  input  wire logic       mosi, // Data in
  input  wire logic       clock_polarity, // Idle level
  input  wire logic       clock_phase, // Phase
  input  wire logic [7:0] tx,   // Byte to send
  output logic            miso, // Data out
  output logic [7:0]      rx    // Byte taken
);
  logic [7:0] sh; // Send shifter
  initial begin
    miso = 1'b0;
    rx = 8'h00;
  end
  // Phase zero puts the first bit out on select
  always @(negedge ss_n) begin
    sh = tx;
    if (!clock_phase) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
  // Released line is no kept value
  always @(posedge ss_n) miso = ~miso;
  // Leading edge leaves idle; phase picks sample or setup
  always @(sck) begin
    if (!ss_n) begin
      if ((sck != clock_polarity) ^ clock_phase) rx = {rx[6:0], mosi};
      else begin
        miso = sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule // spims_slv_model

// ==== spims_top_tb.sv ====
`timescale 1ns/10ps
module spims_top_tb;
  import spims_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, irq_ack, ext_ss, slv;
  logic pready, pslverr, irq, sck, ss_n, miso, m_miso, m_clock_polarity, m_clock_phase;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd_data;
  logic [7:0]        m_tx, m_rx, d;
  logic [2:0]        kb;
  logic              ext_sck, ext_mosi;
  logic [7:0]        q;
  spims_pin_in_s     pin_in;
  spims_pin_out_s    pin_out;
  int                err_count, checks;
  // Shared lines from the drive enables
  assign sck = pin_out.sck_oe ? pin_out.sck_o : ext_sck;
  assign ss_n = pin_out.ss_oe ? pin_out.ss_o : ext_ss;
  assign miso = pin_out.miso_oe ? pin_out.miso_o : m_miso;
  assign pin_in = {sck, pin_out.mosi_oe ? pin_out.mosi_o : ext_mosi, miso,
                   ss_n};
  spims_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_ack, .pin_in, .pin_out, .irq);
  spims_slv_model slv_u (.sck, .ss_n, .mosi(pin_out.mosi_o), .clock_polarity(m_clock_polarity),
    .clock_phase(m_clock_phase), .tx(m_tx), .miso(m_miso), .rx(m_rx));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, got);
    checks++;
    if (got !== ex) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer, held until ready under a bound
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] v);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h000000, v};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      give_verdict();
    end
    rd_data = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] ix, input logic [7:0] ex);
    apb(1'b0, ix, 8'h00);
    cmp($sformatf("reg %h", ix), {24'h000000, ex}, rd_data);
  endtask
  // Poll status until done; a long byte is 1k cycles
  task automatic wdone();
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_STAT, 8'h00);
      n++;
    end while (rd_data[7] !== 1'b1 && n < 400);
    if (n >= 400) begin
      err_count++;
      give_verdict();
    end
  endtask
  // External master, mode 0, half period of four pclk
  task automatic sbyte(input logic [7:0] v, input int nb);
    for (int i = 0; i < nb; i++) begin
      ext_mosi <= v[7 - i];
      repeat (4) @(posedge pclk);
      q = {q[6:0], miso};
      ext_sck <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_sck <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  initial begin
    {presetn, psel, penable, pwrite, irq_ack, m_clock_polarity, m_clock_phase} = 7'h00;
    {paddr, pwdata, m_tx, ext_ss, err_count, checks} = '0;
    ext_ss = 1'b1;
    {ext_sck, ext_mosi, q} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_CTRL, 8'h00);
    rd(IDX_STAT, 8'h00);
    rd(10'h000, 8'h00);
    cmp("slverr", 32'h1, {31'h0, slv});
    // Data write with the port off must not shift
    apb(1'b1, IDX_PINS, 8'h2d);
    apb(1'b1, IDX_CTRL, 8'h10);
    apb(1'b1, IDX_DATA, 8'h81);
    repeat (40) @(posedge pclk);
    rd(IDX_STAT, 8'h00);
    cmp("model rx", 32'h0, {24'h0, m_rx});
    // Every mode, rate code and both bit orders
    for (int k = 0; k < 8; k++) begin
      kb = 3'(k);
      m_clock_polarity = kb[1];
      m_clock_phase = kb[0];
      // MISO is two flops late below divide by eight: constant byte
      m_tx = (k % 4 == 0) ? 8'hff : 8'h3c + 8'(k * 29);
      d = 8'ha5 ^ 8'(k * 37);
      apb(1'b1, IDX_PINS, 8'h3d);
      apb(1'b1, IDX_STAT, {7'h00, kb[2]});
      apb(1'b1, IDX_CTRL, {2'b11, kb[2], 1'b1, kb[1:0], kb[1:0]});
      repeat (2) @(posedge pclk);
      cmp("sck idle", {31'h0, kb[1]}, {31'h0, pin_out.sck_o});
      apb(1'b1, IDX_PINS, 8'h2d);
      apb(1'b1, IDX_DATA, d);
      if (k == 5) apb(1'b1, IDX_DATA, 8'hff);
      wdone();
      cmp("status", {24'h0, 1'b1, k == 5, 5'h0, kb[2]}, rd_data);
      cmp("irq", 32'h1, {31'h0, irq});
      apb(1'b0, IDX_DATA, 8'h00);
      cmp("rx", {24'h0, kb[2] ? rev(m_tx) : m_tx}, rd_data);
      cmp("model rx", {24'h0, kb[2] ? rev(d) : d}, {24'h0, m_rx});
      rd(IDX_STAT, {7'h00, kb[2]});
      cmp("irq", 32'h0, {31'h0, irq});
    end
    // Another master pulls select low
    apb(1'b1, IDX_PINS, 8'h35);
    apb(1'b1, IDX_CTRL, 8'h50);
    ext_ss <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(IDX_CTRL, 8'h40);
    rd(IDX_STAT, 8'h81);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    rd(IDX_STAT, 8'h01);
    ext_ss <= 1'b1;
    apb(1'b1, IDX_CTRL, 8'h50);
    rd(IDX_CTRL, 8'h50);
    // Slave: partial byte dropped on deselect, then a full byte
    apb(1'b1, IDX_PINS, 8'h02);
    apb(1'b1, IDX_CTRL, 8'h40);
    apb(1'b1, IDX_DATA, 8'h5a);
    ext_ss <= 1'b0;
    sbyte(8'hff, 3);
    ext_ss <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_ss <= 1'b0;
    sbyte(8'h96, 8);
    cmp("miso_oe", 32'h1, {31'h0, pin_out.miso_oe});
    ext_ss <= 1'b1;
    cmp("slave tx", 32'h5a, {24'h0, q});
    rd(IDX_STAT, 8'h81);
    rd(IDX_DATA, 8'h96);
    give_verdict();
  end
endmodule // spims_top_tb
